// >>> cct_pkg.sv
package cct_pkg;

    // ----------------------------------------
    // register byte addresses
    // ----------------------------------------
    localparam logic [7:0] ADDR_CTL_ONE = 8'h00;
    localparam logic [7:0] ADDR_CTL_TWO = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_COUNT = 8'h0c;
    localparam logic [7:0] ADDR_CMP_ONE = 8'h10;
    localparam logic [7:0] ADDR_CMP_TWO = 8'h14;
    localparam logic [7:0] ADDR_CAP_ONE = 8'h18;
    localparam logic [7:0] ADDR_CAP_TWO = 8'h1c;

    // ----------------------------------------
    // field positions and reset values
    // ----------------------------------------
    localparam int C1_CAP_IRQ_EN = 7;
    localparam int C1_CMP_IRQ_EN = 6;
    localparam int C1_OVF_IRQ_EN = 5;
    localparam int C1_FORCE_TWO = 4;
    localparam int C1_FORCE_ONE = 3;
    localparam int C1_LEVEL_TWO = 2;
    localparam int C1_CAP_EDGE_ONE = 1;
    localparam int C1_LEVEL_ONE = 0;
    localparam int C2_PIN_ONE_EN = 7;
    localparam int C2_PIN_TWO_EN = 6;
    localparam int C2_ONE_PULSE = 5;
    localparam int C2_PWM = 4;
    localparam int C2_CLK_SEL_HI = 3;
    localparam int C2_CLK_SEL_LO = 2;
    localparam int C2_CAP_EDGE_TWO = 1;
    localparam int C2_EXT_EDGE = 0;
    localparam int ST_CAP_ONE = 7;
    localparam int ST_CMP_ONE = 6;
    localparam int ST_OVF = 5;
    localparam int ST_CAP_TWO = 4;
    localparam int ST_CMP_TWO = 3;
    localparam logic [7:0] CTL_ONE_RESET = 8'h00;
    localparam logic [7:0] CTL_TWO_RESET = 8'h00;
    localparam logic [7:0] STATUS_MASK = 8'hf8;
    localparam logic [15:0] CNT_RELOAD = 16'hfffc;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] CMP_RESET = 16'hffff;

    // ----------------------------------------
    // clock select codes and bus codes
    // ----------------------------------------
    localparam logic [1:0] CLK_DIV4 = 2'h0;
    localparam logic [1:0] CLK_DIV2 = 2'h1;
    localparam logic [1:0] CLK_DIV8 = 2'h2;
    localparam logic [1:0] CLK_EXT = 2'h3;
    localparam logic [2:0] PRESC_DIV2_END = 3'h1;
    localparam logic [2:0] PRESC_DIV4_END = 3'h3;
    localparam logic [2:0] PRESC_DIV8_END = 3'h7;
    localparam logic HRESP_OKAY = 1'b0;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic ext_clk;
        logic cap_one;
        logic cap_two;
    } cct_pins_in_t;

    typedef struct packed {
        logic cmp_one;
        logic cmp_one_oe;
        logic cmp_two;
        logic cmp_two_oe;
    } cct_pins_out_t;

    typedef struct packed {
        logic irq_mask;
        logic wait_state;
        logic halt_state;
    } cct_cpu_t;

    typedef struct packed {
        logic [7:0] ctl1;
        logic [7:0] ctl2;
        logic [7:0] stat;
        logic [15:0] cnt;
        logic [15:0] cmp1;
        logic [15:0] cmp2;
        logic [15:0] cap1;
        logic [15:0] cap2;
        logic pin1;
        logic pin2;
        logic ext_q;
        logic cap1_q;
        logic cap2_q;
        logic [2:0] presc;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
    } cct_state_t;

endpackage

// >>> cct_timer.sv
// Decided for this implementation: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps

// Functional notes
// R1: all timer events share one interrupt line, gated by enables and cpu mask.
// R2: capture enable passes either capture flag to the interrupt.
// R3: compare enable passes either compare flag to the interrupt.
// R4: overflow enable passes the overflow flag to the interrupt.
// R5: enabled events wake cpu from wait, never from halt; no compare events in pwm.
// R6: pwm period end sets the capture one flag.
// R7: force two copies level two to second pin when enabled.
// R8: force one copies level one to first pin when enabled.
// R9: compare two match drives level two; first pin in pwm; in one-pulse the capture one edge drives it.
// R10: capture edge one selects falling (0) or rising (1) edge.
// R11: compare one match copies level one to first pin.
// R12: first pin enable only gates the pin; compare one keeps running.
// R13: second pin enable only gates the pin; compare two keeps running.
// R14: one-pulse mode emits one pulse after capture one edge, width compare one.
// R15: pwm mode repeats; compare one sets pulse, compare two sets period.
// R16: clock select 00 div4, 01 div2, 10 div8, 11 external clock.
// R17: without external pin, external clock setting stops the counter.
// R18: capture edge two selects falling (0) or rising (1) edge.
// R19: external clock edge bit selects falling (0) or rising (1) transition.
// R20: pwm and one-pulse both set acts as pwm only.
// R21: pwm compare two match reloads counter with fffc.
// R22: interrupt is a level held until software clears the flags.
module cct_timer #(
    parameter bit HAS_EXT_CLK = 1'b1
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // timer pins
    input cct_pkg::cct_pins_in_t pins_i,
    output cct_pkg::cct_pins_out_t pins_o,
    // cpu side
    input cct_pkg::cct_cpu_t cpu_i,
    output logic timer_irq,
    output logic cpu_wakeup
);

    cct_pkg::cct_state_t st;
    cct_pkg::cct_state_t nx;

    logic [1:0] clk_sel;
    logic pwm_mode;
    logic pulse_mode;
    logic tick;
    logic ext_edge;
    logic cap1_edge;
    logic cap2_edge;
    logic match1;
    logic match2;
    logic ovf_evt;
    logic [7:0] set_vec;
    logic [7:0] clr_vec;
    logic irq_pend;
    logic addr_take;

    // ----------------------------------------
    // mode decode and event detection
    // ----------------------------------------

    // mode bits, pwm wins over one-pulse
    assign clk_sel = st.ctl2[cct_pkg::C2_CLK_SEL_HI:cct_pkg::C2_CLK_SEL_LO];
    // R15: pwm waveform select
    assign pwm_mode = st.ctl2[cct_pkg::C2_PWM];
    // R20: pwm overrides
    assign pulse_mode = st.ctl2[cct_pkg::C2_ONE_PULSE] & ~pwm_mode;

    // R19: external clock edge select
    assign ext_edge = st.ctl2[cct_pkg::C2_EXT_EDGE] ? (pins_i.ext_clk & ~st.ext_q)
                                                     : (~pins_i.ext_clk & st.ext_q);
    // R10: capture one edge select
    assign cap1_edge = st.ctl1[cct_pkg::C1_CAP_EDGE_ONE] ? (pins_i.cap_one & ~st.cap1_q)
                                                          : (~pins_i.cap_one & st.cap1_q);
    // R18: capture two edge select
    assign cap2_edge = st.ctl2[cct_pkg::C2_CAP_EDGE_TWO] ? (pins_i.cap_two & ~st.cap2_q)
                                                          : (~pins_i.cap_two & st.cap2_q);

    // counter advance enable
    always_comb
    begin
        case (clk_sel)
            // R16: prescaler taps
            cct_pkg::CLK_DIV4: tick = (st.presc[1:0] == cct_pkg::PRESC_DIV4_END[1:0]);
            cct_pkg::CLK_DIV2: tick = (st.presc[0] == cct_pkg::PRESC_DIV2_END[0]);
            cct_pkg::CLK_DIV8: tick = (st.presc == cct_pkg::PRESC_DIV8_END);
            // R17: no pin, no count
            cct_pkg::CLK_EXT: tick = HAS_EXT_CLK & ext_edge;
            default: tick = 1'b0;
        endcase
    end

    // R12: compare one runs whatever the pin enable
    assign match1 = tick & (st.cnt == st.cmp1);
    // R13: compare two runs whatever the pin enable
    assign match2 = tick & (st.cnt == st.cmp2);
    assign ovf_evt = tick & (st.cnt == cct_pkg::CNT_MAX) & ~(pwm_mode & match2);

    // ----------------------------------------
    // status flag set and clear
    // ----------------------------------------

    // hardware set sources per flag
    always_comb
    begin
        set_vec = 8'h00;
        // R6: period end counts as capture one
        set_vec[cct_pkg::ST_CAP_ONE] = (~pwm_mode & ~pulse_mode & cap1_edge)
                                     | (pwm_mode & match2);
        set_vec[cct_pkg::ST_CAP_TWO] = cap2_edge;
        // R5: no compare events in pwm
        set_vec[cct_pkg::ST_CMP_ONE] = match1 & ~pwm_mode & ~pulse_mode;
        set_vec[cct_pkg::ST_CMP_TWO] = match2 & ~pwm_mode;
        set_vec[cct_pkg::ST_OVF] = ovf_evt;
    end

    // write-one-to-clear from the bus data phase
    assign clr_vec = (st.wr_pend && st.wr_addr == cct_pkg::ADDR_STATUS)
                   ? (hwdata[7:0] & cct_pkg::STATUS_MASK) : 8'h00;

    // ----------------------------------------
    // next state
    // ----------------------------------------

    // bus address phase accepted
    assign addr_take = hsel & hready & htrans[1];

    always_comb
    begin
        nx = st;
        nx.ext_q = pins_i.ext_clk;
        nx.cap1_q = pins_i.cap_one;
        nx.cap2_q = pins_i.cap_two;
        nx.presc = st.presc + 3'h1;

        // counter: reload at period end or pulse start, else advance
        if (pwm_mode && match2)
        begin
            // R21: period restart
            nx.cnt = cct_pkg::CNT_RELOAD;
        end
        else if (pulse_mode && cap1_edge)
        begin
            // R14: pulse start restarts the count
            nx.cnt = cct_pkg::CNT_RELOAD;
        end
        else if (tick)
        begin
            nx.cnt = st.cnt + 16'h0001;
        end

        // captures latch the count
        if (set_vec[cct_pkg::ST_CAP_ONE] && !pwm_mode)
        begin
            nx.cap1 = st.cnt;
        end
        if (cap2_edge)
        begin
            nx.cap2 = st.cnt;
        end

        // R22: flags held until cleared, set wins
        nx.stat = (st.stat & ~clr_vec) | set_vec;

        // first compare pin level
        if (st.ctl1[cct_pkg::C1_FORCE_ONE])
        begin
            // R8: forced level one
            nx.pin1 = st.ctl1[cct_pkg::C1_LEVEL_ONE];
        end
        else if ((pwm_mode && match2) || (pulse_mode && cap1_edge))
        begin
            // R9: level two onto first pin
            nx.pin1 = st.ctl1[cct_pkg::C1_LEVEL_TWO];
        end
        else if (match1)
        begin
            // R11: level one on match
            nx.pin1 = st.ctl1[cct_pkg::C1_LEVEL_ONE];
        end

        // second compare pin level
        if (st.ctl1[cct_pkg::C1_FORCE_TWO])
        begin
            // R7: forced level two
            nx.pin2 = st.ctl1[cct_pkg::C1_LEVEL_TWO];
        end
        else if (match2 && !pwm_mode && !pulse_mode)
        begin
            // R9: level two on second pin
            nx.pin2 = st.ctl1[cct_pkg::C1_LEVEL_TWO];
        end

        // bus data phase writes
        nx.wr_pend = 1'b0;
        if (st.wr_pend)
        begin
            case (st.wr_addr)
                cct_pkg::ADDR_CTL_ONE: nx.ctl1 = hwdata[7:0];
                cct_pkg::ADDR_CTL_TWO: nx.ctl2 = hwdata[7:0];
                cct_pkg::ADDR_COUNT:
                begin
                    nx.cnt = cct_pkg::CNT_RELOAD;
                    nx.presc = 3'h0;
                end
                cct_pkg::ADDR_CMP_ONE: nx.cmp1 = hwdata[15:0];
                cct_pkg::ADDR_CMP_TWO: nx.cmp2 = hwdata[15:0];
                default: nx.wr_addr = st.wr_addr;
            endcase
        end

        // bus address phase: latch write, prepare read data
        if (addr_take)
        begin
            nx.wr_pend = hwrite;
            nx.wr_addr = haddr[7:0];
            nx.rdata = 32'h0000_0000;
            if (!hwrite)
            begin
                case (haddr[7:0])
                    cct_pkg::ADDR_CTL_ONE: nx.rdata = {24'h00_0000, st.ctl1};
                    cct_pkg::ADDR_CTL_TWO: nx.rdata = {24'h00_0000, st.ctl2};
                    cct_pkg::ADDR_STATUS: nx.rdata = {24'h00_0000, st.stat};
                    cct_pkg::ADDR_COUNT: nx.rdata = {16'h0000, st.cnt};
                    cct_pkg::ADDR_CMP_ONE: nx.rdata = {16'h0000, st.cmp1};
                    cct_pkg::ADDR_CMP_TWO: nx.rdata = {16'h0000, st.cmp2};
                    cct_pkg::ADDR_CAP_ONE: nx.rdata = {16'h0000, st.cap1};
                    cct_pkg::ADDR_CAP_TWO: nx.rdata = {16'h0000, st.cap2};
                    default: nx.rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // state register, synchronous reset
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            st <= '0;
            st.ctl1 <= cct_pkg::CTL_ONE_RESET;
            st.ctl2 <= cct_pkg::CTL_TWO_RESET;
            st.cnt <= cct_pkg::CNT_RELOAD;
            st.cmp1 <= cct_pkg::CMP_RESET;
            st.cmp2 <= cct_pkg::CMP_RESET;
        end
        else
        begin
            st <= nx;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------

    // interrupt request from enabled flags
    always_comb
    begin
        // R2: capture flags
        irq_pend = (st.stat[cct_pkg::ST_CAP_ONE] | st.stat[cct_pkg::ST_CAP_TWO])
                 & st.ctl1[cct_pkg::C1_CAP_IRQ_EN];
        // R3: compare flags, absent in pwm
        irq_pend = irq_pend | ((st.stat[cct_pkg::ST_CMP_ONE] | st.stat[cct_pkg::ST_CMP_TWO])
                 & st.ctl1[cct_pkg::C1_CMP_IRQ_EN] & ~pwm_mode);
        // R4: overflow flag
        irq_pend = irq_pend | (st.stat[cct_pkg::ST_OVF] & st.ctl1[cct_pkg::C1_OVF_IRQ_EN]);
    end

    // R1: one shared line, cpu mask gates it
    assign timer_irq = irq_pend & ~cpu_i.irq_mask;
    // R5: wait exit only, never halt
    assign cpu_wakeup = timer_irq & cpu_i.wait_state & ~cpu_i.halt_state;

    // pins: level from flops, enables from control two
    assign pins_o.cmp_one = st.pin1;
    assign pins_o.cmp_one_oe = st.ctl2[cct_pkg::C2_PIN_ONE_EN];
    assign pins_o.cmp_two = st.pin2;
    assign pins_o.cmp_two_oe = st.ctl2[cct_pkg::C2_PIN_TWO_EN];

    // zero-wait slave, always okay
    assign hreadyout = 1'b1;
    assign hresp = cct_pkg::HRESP_OKAY;
    assign hrdata = st.rdata;

    // ----------------------------------------
    // assertions
    // ----------------------------------------

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence s_period_end;
        pwm_mode && match2 && !st.wr_pend;
    endsequence

    sequence s_restart_seen;
        st.stat[cct_pkg::ST_CAP_ONE] && st.cnt == cct_pkg::CNT_RELOAD;
    endsequence

    property p_irq_masked;
        cpu_i.irq_mask |-> !timer_irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("irq while masked"); // R1

    property p_cap_irq;
        (st.stat[cct_pkg::ST_CAP_TWO] && st.ctl1[cct_pkg::C1_CAP_IRQ_EN]
            && !cpu_i.irq_mask) |-> timer_irq;
    endproperty
    a_cap_irq: assert property (p_cap_irq) else $error("capture irq missing"); // R2

    property p_cmp_inhibit;
        (timer_irq && !st.ctl1[cct_pkg::C1_CAP_IRQ_EN] && !st.ctl1[cct_pkg::C1_OVF_IRQ_EN])
            |-> st.ctl1[cct_pkg::C1_CMP_IRQ_EN] && !pwm_mode;
    endproperty
    a_cmp_inhibit: assert property (p_cmp_inhibit) else $error("compare irq leak"); // R3

    property p_ovf_irq;
        (ovf_evt && st.ctl1[cct_pkg::C1_OVF_IRQ_EN] && !cpu_i.irq_mask
            && !st.wr_pend) |=> timer_irq || cpu_i.irq_mask;
    endproperty
    a_ovf_irq: assert property (p_ovf_irq) else $error("overflow irq missing"); // R4

    property p_no_halt_wake;
        cpu_wakeup |-> cpu_i.wait_state && !cpu_i.halt_state && timer_irq;
    endproperty
    a_no_halt_wake: assert property (p_no_halt_wake) else $error("bad wakeup"); // R5

    property p_period_end;
        s_period_end |=> s_restart_seen;
    endproperty
    a_period_end: assert property (p_period_end) else $error("pwm restart wrong"); // R21

    property p_force_one;
        st.ctl1[cct_pkg::C1_FORCE_ONE] |=> st.pin1 == $past(st.ctl1[cct_pkg::C1_LEVEL_ONE]);
    endproperty
    a_force_one: assert property (p_force_one) else $error("force one wrong"); // R8

    property p_match_one;
        (match1 && !pwm_mode && !pulse_mode && !st.ctl1[cct_pkg::C1_FORCE_ONE])
            |=> st.pin1 == $past(st.ctl1[cct_pkg::C1_LEVEL_ONE])
                && st.stat[cct_pkg::ST_CMP_ONE];
    endproperty
    a_match_one: assert property (p_match_one) else $error("compare one wrong"); // R11

    property p_capture_one;
        (cap1_edge && !pwm_mode && !pulse_mode)
            |=> st.cap1 == $past(st.cnt) && st.stat[cct_pkg::ST_CAP_ONE];
    endproperty
    a_capture_one: assert property (p_capture_one) else $error("capture one wrong"); // R10

    property p_div2_spacing;
        (clk_sel == cct_pkg::CLK_DIV2 && tick && !st.wr_pend && !addr_take) |=> !tick ##1 tick;
    endproperty
    a_div2_spacing: assert property (p_div2_spacing) else $error("div2 rate wrong"); // R16

    property p_pulse_start;
        (pulse_mode && cap1_edge && !st.ctl1[cct_pkg::C1_FORCE_ONE] && !st.wr_pend)
            |=> st.pin1 == $past(st.ctl1[cct_pkg::C1_LEVEL_TWO])
                && st.cnt == cct_pkg::CNT_RELOAD;
    endproperty
    a_pulse_start: assert property (p_pulse_start) else $error("pulse start wrong"); // R14

endmodule

// >>> cct_pins_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// far side: capture pins and external clock
// ----------------------------------------
module cct_pins_model (
    // clock
    input wire logic ref_clk,
    // requests from the bench
    input wire logic ext_run,
    input wire logic [1:0] cap_lvl,
    // pins into the timer
    output cct_pkg::cct_pins_in_t pins_i
);
    logic ext_r = 1'b0;
    logic [1:0] div_r = 2'h0;

    // ext clock toggles every third cycle, stands low outside frames
    always_ff @(posedge ref_clk)
    begin
        if (!ext_run)
        begin
            div_r <= 2'h0;
            ext_r <= 1'b0;
        end
        else if (div_r == 2'h2)
        begin
            div_r <= 2'h0;
            ext_r <= ~ext_r;
        end
        else
            div_r <= div_r + 2'h1;
    end

    // capture pins follow the bench request
    assign pins_i = '{ext_clk: ext_r, cap_one: cap_lvl[0], cap_two: cap_lvl[1]};
endmodule

// >>> capture_compare_timer_control_tb.sv
`timescale 1ns/1ps

module capture_compare_timer_control_tb;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    cct_pkg::cct_pins_in_t pins_i;
    cct_pkg::cct_pins_out_t pins_o;
    cct_pkg::cct_cpu_t cpu_i = '0;
    logic timer_irq;
    logic cpu_wakeup;
    logic ext_run = 1'b0;
    logic [1:0] cap_lvl = 2'h0;
    int err_total = 0;
    int cmp_count = 0;
    logic [31:0] rd;
    logic [31:0] c0;
    logic [31:0] hrdata2;
    logic [31:0] rd2;
    logic [31:0] c2;
    logic [31:0] exp2;
    logic bad;
    logic seen_hi;
    logic seen_lo;
    // rows: clock select code and count advance over 96 cycles
    logic [7:0] row_ctl [5] = '{8'h00, 8'h04, 8'h08, 8'h0d, 8'h0c};
    logic [31:0] row_exp [5] = '{32'h18, 32'h30, 32'h0c, 32'h10, 32'h10};

    // ----------------------------------------
    // clock, design and far side
    // ----------------------------------------
    always #50 ref_clk = ~ref_clk;

    cct_timer i_dut (
        .ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .pins_i(pins_i), .pins_o(pins_o), .cpu_i(cpu_i), .timer_irq(timer_irq),
        .cpu_wakeup(cpu_wakeup)
    );

    // variant without the external clock pin
    cct_timer #(.HAS_EXT_CLK(1'b0)) i_dut_noext (
        .ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(), .hresp(), .hrdata(hrdata2),
        .pins_i(pins_i), .pins_o(), .cpu_i(cpu_i), .timer_irq(), .cpu_wakeup()
    );

    cct_pins_model i_pins (.ref_clk(ref_clk), .ext_run(ext_run), .cap_lvl(cap_lvl),
        .pins_i(pins_i));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task final_report;
        $display("mismatches %0d comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask

    task tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // bounded wait for hready at a rising edge
    task wait_ready;
        int n;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 64);
        if (hreadyout !== 1'b1)
        begin
            err_total++;
            final_report();
        end
    endtask

    // one single word transfer, read data taken at the data phase edge
    task bus(input logic [7:0] addr, input logic wr, input logic [31:0] wd);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, addr};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        rd2 = hrdata2;
        chk_bit(hresp, 1'b0); // always okay
    endtask

    task wait_irq;
        int n;
        n = 0;
        while (timer_irq !== 1'b1 && n < 400)
        begin
            @(posedge ref_clk);
            n++;
        end
        if (timer_irq !== 1'b1)
        begin
            err_total++;
            final_report();
        end
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        ext_run <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            bus(cct_pkg::ADDR_CTL_TWO, 1'b1, {24'h0, row_ctl[i]});
            bus(cct_pkg::ADDR_COUNT, 1'b0, 32'h0);
            c0 = rd;
            c2 = rd2;
            tick(93);
            bus(cct_pkg::ADDR_COUNT, 1'b0, 32'h0);
            chk_word({16'h0, rd[15:0] - c0[15:0]}, row_exp[i]); // rate
            exp2 = (row_ctl[i][3:2] == cct_pkg::CLK_EXT) ? 32'h0 : row_exp[i];
            chk_word({16'h0, rd2[15:0] - c2[15:0]}, exp2); // no-pin variant: counter stopped on external clock, same rate otherwise
        end
        ext_run <= 1'b0;
        bus(cct_pkg::ADDR_CTL_TWO, 1'b1, 32'hc4);
        bus(cct_pkg::ADDR_CTL_ONE, 1'b1, 32'h1c);
        tick(3);
        chk_word({28'h0, pins_o}, 32'h7); // force levels
        bus(cct_pkg::ADDR_CTL_ONE, 1'b1, 32'h19);
        tick(3);
        chk_word({28'h0, pins_o}, 32'hd); // force levels
        bus(cct_pkg::ADDR_CTL_ONE, 1'b1, 32'h44);
        bus(cct_pkg::ADDR_CMP_ONE, 1'b1, 32'h2);
        bus(cct_pkg::ADDR_CMP_TWO, 1'b1, 32'h3);
        bus(cct_pkg::ADDR_COUNT, 1'b1, 32'h0);
        bus(cct_pkg::ADDR_STATUS, 1'b1, 32'hf8);
        tick(1);
        wait_irq();
        tick(4);
        bus(cct_pkg::ADDR_STATUS, 1'b0, 32'h0);
        chk_word(rd & 32'hf8, 32'h68); // flags
        chk_word({28'h0, pins_o}, 32'h7); // match levels
        cpu_i.irq_mask <= 1'b1;
        tick(2);
        chk_bit(timer_irq, 1'b0); // masked
        cpu_i <= '{irq_mask: 1'b0, wait_state: 1'b1, halt_state: 1'b0};
        tick(2);
        chk_bit(cpu_wakeup, 1'b1); // wait exit
        cpu_i.halt_state <= 1'b1;
        tick(2);
        chk_bit(cpu_wakeup, 1'b0); // no halt exit
        chk_bit(timer_irq, 1'b1); // held level
        bus(cct_pkg::ADDR_STATUS, 1'b1, 32'h48);
        tick(2);
        chk_bit(timer_irq, 1'b0); // inhibited
        bus(cct_pkg::ADDR_CTL_ONE, 1'b1, 32'h24);
        tick(2);
        chk_bit(timer_irq, 1'b1); // overflow
        for (int e = 0; e < 2; e++)
        begin
            bus(cct_pkg::ADDR_CTL_ONE, 1'b1, e ? 32'h82 : 32'h0);
            bus(cct_pkg::ADDR_CTL_TWO, 1'b1, e ? 32'hc6 : 32'hc4);
            bus(cct_pkg::ADDR_STATUS, 1'b1, 32'hf8);
            cap_lvl <= 2'h3;
            tick(4);
            bus(cct_pkg::ADDR_STATUS, 1'b0, 32'h0);
            chk_word(rd & 32'h90, e ? 32'h90 : 32'h0); // rising
            chk_bit(timer_irq, e[0]); // capture enable
            bus(cct_pkg::ADDR_STATUS, 1'b1, 32'hf8);
            cap_lvl <= 2'h0;
            tick(4);
            bus(cct_pkg::ADDR_STATUS, 1'b0, 32'h0);
            chk_word(rd & 32'h90, e ? 32'h0 : 32'h90); // falling
            chk_bit(timer_irq, 1'b0); // inhibited
        end
        // pwm with one pulse also set
        bus(cct_pkg::ADDR_CTL_ONE, 1'b1, 32'h44);
        bus(cct_pkg::ADDR_CMP_ONE, 1'b1, 32'h8);
        bus(cct_pkg::ADDR_CMP_TWO, 1'b1, 32'h10);
        bus(cct_pkg::ADDR_CTL_TWO, 1'b1, 32'hb4);
        bus(cct_pkg::ADDR_COUNT, 1'b1, 32'h0);
        bus(cct_pkg::ADDR_STATUS, 1'b1, 32'hf8);
        bad = 1'b0;
        seen_hi = 1'b0;
        seen_lo = 1'b0;
        for (int k = 0; k < 60; k++)
        begin
            bus(cct_pkg::ADDR_COUNT, 1'b0, 32'h0);
            bad |= !(rd[15:0] >= 16'hfffc || rd[15:0] <= 16'h0010);
            seen_hi |= (pins_o.cmp_one === 1'b1);
            seen_lo |= (pins_o.cmp_one === 1'b0);
        end
        chk_bit(bad, 1'b0); // reload range
        chk_bit(seen_hi & seen_lo, 1'b1); // repeating wave
        bus(cct_pkg::ADDR_STATUS, 1'b0, 32'h0);
        chk_word(rd & 32'hc8, 32'h80); // flags in pwm
        chk_bit(timer_irq, 1'b0); // no compare irq
        bus(cct_pkg::ADDR_CTL_ONE, 1'b1, 32'hc4);
        tick(2);
        chk_bit(timer_irq, 1'b1); // shared enable
        // one-pulse mode alone, rising edge on capture one
        bus(cct_pkg::ADDR_CTL_TWO, 1'b1, 32'ha4);
        bus(cct_pkg::ADDR_CTL_ONE, 1'b1, 32'h08);
        bus(cct_pkg::ADDR_CTL_ONE, 1'b1, 32'h06);
        bus(cct_pkg::ADDR_STATUS, 1'b1, 32'hf8);
        cap_lvl <= 2'h1;
        tick(3);
        chk_bit(pins_o.cmp_one, 1'b1); // pulse start
        tick(16);
        chk_bit(pins_o.cmp_one, 1'b1); // pulse still high
        tick(20);
        chk_bit(pins_o.cmp_one, 1'b0); // pulse end at compare one
        bus(cct_pkg::ADDR_STATUS, 1'b0, 32'h0);
        chk_word(rd & 32'hc0, 32'h0); // no capture or compare one flag
        cap_lvl <= 2'h0;
        // unmapped read returns zero
        bus(8'h20, 1'b0, 32'h0);
        chk_word(rd, 32'h0);
        // second reset in mid run
        bus(cct_pkg::ADDR_CTL_ONE, 1'b1, 32'hff);
        resetn <= 1'b0;
        tick(2);
        resetn <= 1'b1;
        bus(cct_pkg::ADDR_CTL_ONE, 1'b0, 32'h0);
        chk_word(rd, 32'h0); // control one reset
        bus(cct_pkg::ADDR_CTL_TWO, 1'b0, 32'h0);
        chk_word(rd, 32'h0); // control two reset
        chk_word({28'h0, pins_o}, 32'h0); // pins released
        chk_bit(timer_irq, 1'b0); // no request
        final_report();
    end
endmodule
